// [common/vlan_lookup_pkg.sv]
// Constants, encodings and layouts of the VLAN table and lookup key registers.
// Assumes a single core clock and a plain byte-lane register port.
//
// Contract
// - Hold seven-bit egress untag map per row.
// - Hold forward map, applied only with option.
// - Twelve-bit row selector, upper nibble reads zero.
// - Go bit set by host, self-clears when done.
// - Actions: none, write, read, clear all rows.
// - Action targets row selected at start.
// - Filter identifier from key high, bits 22:16.
// - Address bits 47:32 from key high low half.
// - Address bits 31:0 from key low register.
// - Direct mode uses key low bits 11:0.
// - Key registers feed every lookup table action.
// - Per-row forward option selects forward map.
// - Lookup actions: none, write, read, search.
// - Direct bit picks direct or hashed indexing.
package vlan_lookup_pkg;

	localparam logic [15:0] OFS_UNTAG = 16'h0404;
	localparam logic [15:0] OFS_FORWARD = 16'h0408;
	localparam logic [15:0] OFS_SELECTOR = 16'h040c;
	localparam logic [15:0] OFS_COMMAND = 16'h040e;
	localparam logic [15:0] OFS_KEY_HIGH = 16'h0410;
	localparam logic [15:0] OFS_KEY_LOW = 16'h0414;

	localparam int PORT_MAP_W = 7;
	localparam int ROW_SEL_W = 12;
	localparam int FILTER_ID_W = 7;
	localparam int STATION_ADDR_W = 48;
	localparam int DIRECT_ROW_W = 12;

	localparam int COMMAND_SHIFT = 16;
	localparam int GO_DONE_POS = 7;
	localparam int FILTER_ID_LSB = 16;
	localparam int ADDR_HIGH_W = 16;

	localparam int ROW_UNTAG_LSB = 0;
	localparam int ROW_FORWARD_LSB = 7;
	localparam int ROW_OPTION_POS = 14;
	localparam int ROW_W = 15;

	localparam logic [31:0] MASK_PORT_MAP = 32'h0000007f;
	localparam logic [31:0] MASK_SELECTOR = 32'h00000fff;
	localparam logic [31:0] MASK_KEY_HIGH = 32'h807fffff;
	localparam logic [31:0] MASK_KEY_LOW = 32'hffffffff;

	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [6:0] RST_PORT_MAP = 7'h00;
	localparam logic [11:0] RST_SELECTOR = 12'h000;

	typedef enum logic [1:0] {
		VLAN_NOP,
		VLAN_WRITE,
		VLAN_READ,
		VLAN_CLEAR
	} vlanAction_t;

	typedef enum logic [1:0] {
		LOOKUP_NOP,
		LOOKUP_WRITE,
		LOOKUP_READ,
		LOOKUP_SEARCH
	} lookupAction_t;

endpackage

// [logic/vlan_row_memory.sv]
// VLAN table storage: one read/write port for the host, one read port
// for forwarding. Both read results come out of registers.
// Assumes the caller never writes and reads the same row in one cycle.
module vlan_row_memory #(
	parameter int WIDTH = 15,
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic aEnable,
	input wire logic aWrite,
	input wire logic [ADDR_W-1:0] aAddr,
	input wire logic [WIDTH-1:0] aWriteData,
	output logic [WIDTH-1:0] aReadData,
	input wire logic [ADDR_W-1:0] bAddr,
	output logic [WIDTH-1:0] bReadData
);

	logic [WIDTH-1:0] rows [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk) begin
		if (aEnable && aWrite) begin
			rows[aAddr] <= aWriteData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aReadData <= '0;
			bReadData <= '0;
		end else begin
			if (aEnable && !aWrite) begin
				aReadData <= rows[aAddr];
			end
			bReadData <= rows[bAddr];
		end
	end

endmodule

// [logic/vlan_and_lookup_table_access.sv]
// Register front end for the VLAN table and the address lookup key.
// Assumes a byte-lane register port sampled on clk and a lookup engine
// and forwarding path that consume the key and table outputs.
module vlan_and_lookup_table_access #(
	parameter int ROW_ADDR_W = vlan_lookup_pkg::ROW_SEL_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [15:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [3:0] regByteEn,
	input wire logic [31:0] regWriteData,
	output logic [31:0] regReadData,
	input wire logic forwardOptionIn,
	output logic forwardOptionOut,
	output logic tableBusy,
	input wire logic [vlan_lookup_pkg::ROW_SEL_W-1:0] fwdVlanRow,
	output logic [vlan_lookup_pkg::PORT_MAP_W-1:0] fwdUntagMap,
	output logic [vlan_lookup_pkg::PORT_MAP_W-1:0] fwdPortMap,
	output logic fwdForwardOption,
	input wire logic lookupStart,
	input wire logic [1:0] lookupAction,
	input wire logic lookupDirect,
	output logic [vlan_lookup_pkg::FILTER_ID_W-1:0] lookupFilterId,
	output logic [vlan_lookup_pkg::STATION_ADDR_W-1:0] lookupAddress,
	output logic [vlan_lookup_pkg::DIRECT_ROW_W-1:0] lookupRow,
	output logic lookupUseHash,
	output logic lookupDoWrite,
	output logic lookupDoRead,
	output logic lookupDoSearch
);
	import vlan_lookup_pkg::*;

	typedef enum logic [1:0] {
		IDLE,
		READ_LOAD,
		CLEAR_SWEEP
	} tableState_t;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be,
		input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State.

	logic [PORT_MAP_W-1:0] untagQ, untagD;
	logic [PORT_MAP_W-1:0] forwardQ, forwardD;
	logic forwardOptionQ, forwardOptionD;
	logic [ROW_SEL_W-1:0] selectorQ, selectorD;
	logic goQ, goD;
	vlanAction_t actionQ, actionD;
	logic [ROW_ADDR_W-1:0] rowLatchQ, rowLatchD;
	logic [31:0] keyHighQ, keyHighD;
	logic [31:0] keyLowQ, keyLowD;
	tableState_t stateQ, stateD;
	logic [ROW_ADDR_W-1:0] sweepQ, sweepD;
	logic [31:0] readDataQ, readDataD;

	////////////////////////////////////////////////////////////////////////
	// Register decode.

	wire [15:0] wordAddr = {regAddr[15:2], 2'b00};
	wire hitUntag = wordAddr == OFS_UNTAG;
	wire hitForward = wordAddr == OFS_FORWARD;
	wire hitSelWord = wordAddr == OFS_SELECTOR;
	wire hitKeyHigh = wordAddr == OFS_KEY_HIGH;
	wire hitKeyLow = wordAddr == OFS_KEY_LOW;

	// Entry and command writes are dropped while an action runs, so a
	// careless host cannot tear a row half way through.
	wire hostWr = regWrite && !goQ;
	wire cmdWrite = hostWr && hitSelWord && regByteEn[COMMAND_SHIFT/8];
	wire [7:0] cmdByte = regWriteData[COMMAND_SHIFT +: 8];

	wire [31:0] untagMerged = merge({25'h0, untagQ}, regWriteData,
		regByteEn, MASK_PORT_MAP);
	wire [31:0] forwardMerged = merge({25'h0, forwardQ}, regWriteData,
		regByteEn, MASK_PORT_MAP);
	wire [31:0] selMerged = merge({20'h0, selectorQ}, regWriteData,
		regByteEn, MASK_SELECTOR);
	wire [31:0] keyHighMerged = merge(keyHighQ, regWriteData, regByteEn,
		MASK_KEY_HIGH);
	wire [31:0] keyLowMerged = merge(keyLowQ, regWriteData, regByteEn,
		MASK_KEY_LOW);

	////////////////////////////////////////////////////////////////////////
	// Table sequencing.

	wire [ROW_W-1:0] memRow;
	wire startNow = (stateQ == IDLE) && goQ;
	wire memWrite = (startNow && actionQ == VLAN_WRITE) ||
		(stateQ == CLEAR_SWEEP);
	wire memEnable = memWrite || (startNow && actionQ == VLAN_READ);
	wire [ROW_ADDR_W-1:0] memAddr = (stateQ == CLEAR_SWEEP) ? sweepQ :
		rowLatchQ;
	wire [ROW_W-1:0] memWriteData = (stateQ == CLEAR_SWEEP) ? '0 :
		{forwardOptionIn, forwardQ, untagQ};
	wire sweepLast = sweepQ == {ROW_ADDR_W{1'b1}};
	wire goClear = (startNow && (actionQ == VLAN_WRITE ||
		actionQ == VLAN_NOP)) || (stateQ == READ_LOAD) ||
		(stateQ == CLEAR_SWEEP && sweepLast);
	wire loadRow = stateQ == READ_LOAD;

	assign untagD = loadRow ? memRow[ROW_UNTAG_LSB +: PORT_MAP_W] :
		(hostWr && hitUntag) ? untagMerged[PORT_MAP_W-1:0] :
		untagQ;
	assign forwardD = loadRow ? memRow[ROW_FORWARD_LSB +: PORT_MAP_W] :
		(hostWr && hitForward) ? forwardMerged[PORT_MAP_W-1:0] :
		forwardQ;
	assign forwardOptionD = loadRow ? memRow[ROW_OPTION_POS] :
		forwardOptionQ;
	assign selectorD = (hostWr && hitSelWord) ?
		selMerged[ROW_SEL_W-1:0] : selectorQ;
	assign goD = cmdWrite ? cmdByte[GO_DONE_POS] :
		goClear ? 1'b0 : goQ;
	assign actionD = cmdWrite ? vlanAction_t'(cmdByte[1:0]) : actionQ;
	assign rowLatchD = (cmdWrite && cmdByte[GO_DONE_POS]) ?
		selectorD[ROW_ADDR_W-1:0] : rowLatchQ;
	assign keyHighD = (hostWr && hitKeyHigh) ? keyHighMerged : keyHighQ;
	assign keyLowD = (hostWr && hitKeyLow) ? keyLowMerged : keyLowQ;
	assign sweepD = (stateQ == CLEAR_SWEEP) ?
		ROW_ADDR_W'(sweepQ + 1'b1) : '0;

	always_comb begin
		stateD = stateQ;
		case (stateQ)
			IDLE: begin
				if (goQ && actionQ == VLAN_READ) begin
					stateD = READ_LOAD;
				end else if (goQ && actionQ == VLAN_CLEAR) begin
					stateD = CLEAR_SWEEP;
				end
			end
			READ_LOAD: begin
				stateD = IDLE;
			end
			CLEAR_SWEEP: begin
				if (sweepLast) begin
					stateD = IDLE;
				end
			end
			default: begin
				stateD = IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read path.

	wire [31:0] selWord = {8'h00, goQ, 5'h00, actionQ, 4'h0, selectorQ};
	wire [31:0] readMux = hitUntag ? {25'h0, untagQ} :
		hitForward ? {25'h0, forwardQ} :
		hitSelWord ? selWord :
		hitKeyHigh ? keyHighQ :
		hitKeyLow ? keyLowQ : RST_WORD;
	assign readDataD = regRead ? readMux : readDataQ;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			untagQ <= RST_PORT_MAP;
			forwardQ <= RST_PORT_MAP;
			forwardOptionQ <= 1'b0;
			selectorQ <= RST_SELECTOR;
			goQ <= 1'b0;
			actionQ <= VLAN_NOP;
			rowLatchQ <= '0;
			keyHighQ <= RST_WORD;
			keyLowQ <= RST_WORD;
			stateQ <= IDLE;
			sweepQ <= '0;
			readDataQ <= RST_WORD;
		end else begin
			untagQ <= untagD;
			forwardQ <= forwardD;
			forwardOptionQ <= forwardOptionD;
			selectorQ <= selectorD;
			goQ <= goD;
			actionQ <= actionD;
			rowLatchQ <= rowLatchD;
			keyHighQ <= keyHighD;
			keyLowQ <= keyLowD;
			stateQ <= stateD;
			sweepQ <= sweepD;
			readDataQ <= readDataD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table storage and forwarding view.

	wire [ROW_W-1:0] fwdRow;

	vlan_row_memory #(
		.WIDTH(ROW_W),
		.ADDR_W(ROW_ADDR_W)
	) rowStore (
		.clk(clk),
		.rstn(rstn),
		.aEnable(memEnable),
		.aWrite(memWrite),
		.aAddr(memAddr),
		.aWriteData(memWriteData),
		.aReadData(memRow),
		.bAddr(fwdVlanRow[ROW_ADDR_W-1:0]),
		.bReadData(fwdRow)
	);

	assign fwdUntagMap = fwdRow[ROW_UNTAG_LSB +: PORT_MAP_W];
	assign fwdForwardOption = fwdRow[ROW_OPTION_POS];
	// Without the option the map is withheld; other lookups decide.
	assign fwdPortMap = fwdRow[ROW_OPTION_POS] ?
		fwdRow[ROW_FORWARD_LSB +: PORT_MAP_W] : '0;

	assign regReadData = readDataQ;
	assign forwardOptionOut = forwardOptionQ;
	assign tableBusy = goQ;

	////////////////////////////////////////////////////////////////////////
	// Lookup key and action decode.

	assign lookupFilterId = keyHighQ[FILTER_ID_LSB +: FILTER_ID_W];
	assign lookupAddress = {keyHighQ[ADDR_HIGH_W-1:0], keyLowQ};
	assign lookupUseHash = !lookupDirect;
	assign lookupRow = lookupDirect ? keyLowQ[DIRECT_ROW_W-1:0] :
		'0;
	assign lookupDoWrite = lookupStart &&
		lookupAction == LOOKUP_WRITE;
	assign lookupDoRead = lookupStart && lookupAction == LOOKUP_READ;
	assign lookupDoSearch = lookupStart &&
		lookupAction == LOOKUP_SEARCH;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_write_done;
		@(posedge clk) disable iff (!rstn)
		(startNow && actionQ == VLAN_WRITE) |-> memWrite ##1 !goQ;
	endproperty
	a_write_done: assert property (p_write_done)
		else $error("Write action did not finish in one cycle.");

	property p_read_load;
		@(posedge clk) disable iff (!rstn)
		(startNow && actionQ == VLAN_READ) |-> ##1 loadRow ##1
			(!goQ && untagQ == $past(memRow[PORT_MAP_W-1:0]));
	endproperty
	a_read_load: assert property (p_read_load)
		else $error("Read action did not load the entry registers.");

	property p_sel_upper_zero;
		@(posedge clk) disable iff (!rstn)
		(regRead && hitSelWord) |=> regReadData[15:12] == 4'h0;
	endproperty
	a_sel_upper_zero: assert property (p_sel_upper_zero)
		else $error("Selector upper bits read nonzero.");

	// Host writes are locked out while busy, so the row latched with the
	// go bit must still match the selector when the action starts.
	property p_row_latched;
		@(posedge clk) disable iff (!rstn)
		(memEnable && stateQ == IDLE) |-> memAddr == rowLatchQ &&
			rowLatchQ == selectorQ[ROW_ADDR_W-1:0];
	endproperty
	a_row_latched: assert property (p_row_latched)
		else $error("Table action used a row other than the latched one.");

	property p_direct_row;
		@(posedge clk) disable iff (!rstn)
		lookupDirect |-> !lookupUseHash &&
			lookupRow == keyLowQ[DIRECT_ROW_W-1:0];
	endproperty
	a_direct_row: assert property (p_direct_row)
		else $error("Direct row differs from key low bits.");

	property p_addr_high;
		@(posedge clk) disable iff (!rstn)
		(hostWr && hitKeyHigh && regByteEn == 4'hf) |=>
			lookupAddress[47:32] == $past(regWriteData[15:0]) &&
			lookupFilterId == $past(regWriteData[22:16]);
	endproperty
	a_addr_high: assert property (p_addr_high)
		else $error("Key high write not reflected in lookup key.");

	property p_search_decode;
		@(posedge clk) disable iff (!rstn)
		(lookupStart && lookupAction == 2'h3) |->
			lookupDoSearch && !lookupDoRead && !lookupDoWrite;
	endproperty
	a_search_decode: assert property (p_search_decode)
		else $error("Search code decoded wrongly.");

	property p_forward_gate;
		@(posedge clk) disable iff (!rstn)
		!fwdForwardOption |-> fwdPortMap == 7'h00;
	endproperty
	a_forward_gate: assert property (p_forward_gate)
		else $error("Forward map applied without the option bit.");

	property p_clear_zero;
		@(posedge clk) disable iff (!rstn)
		(stateQ == CLEAR_SWEEP) |-> memWrite && memWriteData == '0 &&
			goQ;
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("Clear sweep wrote a nonzero row.");

endmodule

// [sim/vlan_and_lookup_table_access_bench.sv]
// Self-checking bench for the VLAN table and lookup key register front end.
// Assumes the design package is compiled first; drives every input itself.
module vlan_and_lookup_table_access_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import vlan_lookup_pkg::*;

	`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
		mismatches++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
		end end

	////////////////////////////////////////////////////////////////////////
	// A short row address keeps the clear sweep to sixteen cycles.
	localparam int ROWS_W = 4;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [3:0] regByteEn = 4'h0;
	logic [31:0] regWriteData = 32'h00000000;
	logic [31:0] regReadData;
	logic forwardOptionIn = 1'b0;
	logic forwardOptionOut, tableBusy, fwdForwardOption;
	logic [11:0] fwdVlanRow = 12'h000;
	logic [6:0] fwdUntagMap, fwdPortMap;
	logic lookupStart = 1'b0;
	logic [1:0] lookupAction = 2'h0;
	logic lookupDirect = 1'b0;
	logic [6:0] lookupFilterId;
	logic [47:0] lookupAddress;
	logic [11:0] lookupRow;
	logic lookupUseHash, lookupDoWrite, lookupDoRead, lookupDoSearch;
	int mismatches = 0;
	int nCompared = 0;

	vlan_and_lookup_table_access #(.ROW_ADDR_W(ROWS_W)) uut (
		.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regByteEn(regByteEn),
		.regWriteData(regWriteData), .regReadData(regReadData),
		.forwardOptionIn(forwardOptionIn),
		.forwardOptionOut(forwardOptionOut), .tableBusy(tableBusy),
		.fwdVlanRow(fwdVlanRow), .fwdUntagMap(fwdUntagMap),
		.fwdPortMap(fwdPortMap), .fwdForwardOption(fwdForwardOption),
		.lookupStart(lookupStart), .lookupAction(lookupAction),
		.lookupDirect(lookupDirect), .lookupFilterId(lookupFilterId),
		.lookupAddress(lookupAddress), .lookupRow(lookupRow),
		.lookupUseHash(lookupUseHash), .lookupDoWrite(lookupDoWrite),
		.lookupDoRead(lookupDoRead), .lookupDoSearch(lookupDoSearch));

	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic endSim();
		$display("Comparisons %0d, mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge clk);
		regAddr = a;
		regByteEn = be;
		regWriteData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		`CHK("regReadData", e, regReadData)
	endtask

	// Selector and command share one word; lane 2 carries the command.
	task automatic cmd(input logic [7:0] c, input logic [11:0] s);
		wr(OFS_SELECTOR, 4'b0111, {8'h00, c, 4'h0, s});
	endtask

	// Polls the go bit under a bound so a stuck action cannot hang the run.
	task automatic waitIdle();
		int n;
		n = 0;
		`CHK("tableBusy", 1'b1, tableBusy)
		while (tableBusy !== 1'b0 && n < 200) begin
			@(negedge clk);
			n++;
		end
		`CHK("tableBusy", 1'b0, tableBusy)
	endtask

	task automatic fwdChk(input int r, input logic [6:0] u,
		input logic [6:0] f, input logic o);
		@(negedge clk);
		fwdVlanRow = 12'(r);
		@(negedge clk);
		`CHK("fwdUntagMap", u, fwdUntagMap)
		`CHK("fwdPortMap", o ? f : 7'h00, fwdPortMap)
		`CHK("fwdForwardOption", o, fwdForwardOption)
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(20000 * 4);
		mismatches++;
		endSim();
	end

	initial begin
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		rd(OFS_UNTAG, 32'h0);
		rd(OFS_FORWARD, 32'h0);
		rd(OFS_SELECTOR, 32'h0);
		rd(OFS_KEY_HIGH, 32'h0);
		rd(OFS_KEY_LOW, 32'h0);
		rd(16'h0500, 32'h0);
		wr(OFS_UNTAG, 4'hf, 32'hffffffff);
		rd(OFS_UNTAG, 32'h7f);
		wr(OFS_FORWARD, 4'hf, 32'hffffffff);
		rd(OFS_FORWARD, 32'h7f);
		wr(OFS_SELECTOR, 4'b0011, 32'hffffffff);
		rd(OFS_SELECTOR, 32'h00000fff);
		// Each row gets its own pattern so a wrong row shows up later.
		for (int r = 0; r < 4; r++) begin
			wr(OFS_UNTAG, 4'hf, 32'(r * 9 + 1));
			wr(OFS_FORWARD, 4'hf, 32'(7'h7f - r));
			forwardOptionIn = r[0];
			cmd(8'h81, 12'(r));
			waitIdle();
		end
		for (int r = 0; r < 4; r++) begin
			fwdChk(r, 7'(r * 9 + 1), 7'(7'h7f - r), r[0]);
		end
		wr(OFS_UNTAG, 4'hf, 32'h0);
		wr(OFS_FORWARD, 4'hf, 32'h0);
		forwardOptionIn = 1'b0;
		cmd(8'h82, 12'h003);
		waitIdle();
		rd(OFS_UNTAG, 32'h1c);
		rd(OFS_FORWARD, 32'h7c);
		`CHK("forwardOptionOut", 1'b1, forwardOptionOut)
		rd(OFS_SELECTOR, 32'h00020003);
		cmd(8'h80, 12'h001);
		waitIdle();
		wr(OFS_UNTAG, 4'hf, 32'h11);
		cmd(8'h83, 12'h000);
		// Writes during an action are dropped, protecting the entry copy.
		wr(OFS_UNTAG, 4'hf, 32'h22);
		waitIdle();
		rd(OFS_UNTAG, 32'h11);
		for (int r = 0; r < 4; r++) begin
			fwdChk(r, 7'h00, 7'h00, 1'b0);
		end
		wr(OFS_KEY_HIGH, 4'hf, 32'hffffffff);
		rd(OFS_KEY_HIGH, 32'h807fffff);
		wr(OFS_KEY_LOW, 4'hf, 32'h12345abc);
		rd(OFS_KEY_LOW, 32'h12345abc);
		`CHK("lookupFilterId", 7'h7f, lookupFilterId)
		`CHK("lookupAddress", 48'hffff12345abc, lookupAddress)
		`CHK("lookupUseHash", 1'b1, lookupUseHash)
		@(negedge clk);
		lookupDirect = 1'b1;
		#1;
		`CHK("lookupRow", 12'habc, lookupRow)
		`CHK("lookupUseHash", 1'b0, lookupUseHash)
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			lookupStart = i[2];
			lookupAction = 2'(i);
			#1;
			`CHK("lookupDoWrite", i == 5, lookupDoWrite)
			`CHK("lookupDoRead", i == 6, lookupDoRead)
			`CHK("lookupDoSearch", i == 7, lookupDoSearch)
		end
		// Let one rising edge see the search code so its check is exercised.
		@(negedge clk);
		lookupStart = 1'b0;
		endSim();
	end
endmodule
